// ---- src/axi_lite_port.v ----
// AXI4-Lite slave handshake front end for the sequencer registers.
`timescale 1ns/10ps
`include "charge_seq_defines.vh"
module axi_lite_port (
    input wire mclk,
    input wire rst,
    input wire [3:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [3:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output wire wrEn,
    output reg [3:0] wrAddr,
    output reg [31:0] wrData,
    output reg [3:0] wrStrb,
    input wire wrOk,
    output wire [3:0] rdAddr,
    input wire [31:0] rdData,
    input wire rdOk
);
    reg awHeld;
    reg wHeld;

    // Address and data are held separately so either may arrive first.
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign wrEn = awHeld && wHeld && !bvalid;
    assign arready = !rvalid;
    assign rdAddr = araddr;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wrAddr <= 4'h0;
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                wrAddr <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            if (wrEn) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdData;
            rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// ---- src/charge_cycle_sequencer.v ----
// Charge cycle sequencer: phase control, safety timers, indicators, registers.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "charge_seq_defines.vh"
module charge_cycle_sequencer #(
    parameter HALF_PERIOD_CYCLES = `MCLK_HZ / (2 * `FLASH_HZ)
) (
    input wire mclk,
    input wire rst,
    input wire supplyLockout,
    input wire chargePermitIn,
    input wire cellTempSenseOk,
    input wire regulationLevelSelect,
    input wire trickleExitReached,
    input wire targetVoltageReached,
    input wire termCurrentReached,
    input wire belowRechargeThreshold,
    input wire thermalRegActive,
    input wire [3:0] currentShare,
    output reg trickleMode,
    output reg bulkMode,
    output reg voltageMode,
    output reg targetHigh,
    output reg lowPower,
    input wire chargeIndicatorIn,
    output wire chargeIndicatorOut,
    output reg chargeIndicatorOeN,
    input wire faultIndicatorIn,
    output wire faultIndicatorOut,
    output reg faultIndicatorOeN,
    input wire [3:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    input wire [3:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready
);
    // =========================================================
    // Phase codes
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_QUAL = 3'h1;
    localparam [2:0] ST_TRICKLE = 3'h2;
    localparam [2:0] ST_BULK = 3'h3;
    localparam [2:0] ST_VOLTAGE = 3'h4;
    localparam [2:0] ST_DONE = 3'h5;
    localparam [2:0] ST_FAULT = 3'h6;

    localparam [15:0] TRICKLE_TICKS = `TRICKLE_LIMIT_TENTHS_H * `HALF_SECONDS_PER_TENTH_H;
    localparam [15:0] BULK_TICKS = `BULK_LIMIT_TENTHS_H * `HALF_SECONDS_PER_TENTH_H;
    localparam [15:0] OVERALL_TICKS = `OVERALL_LIMIT_TENTHS_H * `HALF_SECONDS_PER_TENTH_H;
    localparam [31:0] HALF_LAST = HALF_PERIOD_CYCLES - 1;

    reg [2:0] state;
    reg [2:0] next_state;
    reg flashOnComplete;
    reg [7:0] capRatio;
    reg [31:0] baseCount;
    reg [7:0] capCount;
    reg oscTick;
    reg flashPhase;
    reg [3:0] slowAcc;
    reg timerAdvance;
    reg chargeOn;
    reg faultOn;

    wire [4:0] slowSum;
    wire [7:0] capLast;
    wire suspended;
    wire qualified;
    wire trickleExpired;
    wire bulkExpired;
    wire overallExpired;
    wire wrEn;
    wire [3:0] wrAddr;
    wire [31:0] wrData;
    wire [3:0] wrStrb;
    wire wrOk;
    wire [3:0] rdAddr;
    reg [31:0] rdData;
    reg rdOk;

    // =========================================================
    // Capacitor clock
    // Base divider: half a second at 0.1 uF; capRatio counts 0.1 uF units.
    assign capLast = (capRatio == 8'h00) ? 8'h00 : capRatio - 8'h01;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            baseCount <= 32'h00000000;
            capCount <= 8'h00;
            oscTick <= 1'b0;
        end else begin
            oscTick <= 1'b0;
            if (baseCount >= HALF_LAST) begin
                baseCount <= 32'h00000000;
                if (capCount >= capLast) begin
                    capCount <= 8'h00;
                    oscTick <= 1'b1;
                end else begin
                    capCount <= capCount + 8'h01;
                end
            end else begin
                baseCount <= baseCount + 32'h00000001;
            end
        end
    end

    // Flash toggles every half period of the capacitor clock.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            flashPhase <= 1'b0;
        end else if (oscTick) begin
            flashPhase <= !flashPhase;
        end
    end

    // =========================================================
    // Thermal slow-down
    // A tick counts only as often as the current share allows, stretching timers.
    assign slowSum = {1'b0, slowAcc} + {1'b0, currentShare};

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            slowAcc <= 4'h0;
            timerAdvance <= 1'b0;
        end else if (!thermalRegActive) begin
            slowAcc <= 4'h0;
            timerAdvance <= oscTick;
        end else if (oscTick) begin
            slowAcc <= slowSum[3:0];
            timerAdvance <= slowSum[4];
        end else begin
            timerAdvance <= 1'b0;
        end
    end

    // =========================================================
    // Safety timers
    // Timers hold their count while suspended and clear outside their phase.
    assign suspended = !cellTempSenseOk && (state == ST_QUAL ||
        state == ST_TRICKLE || state == ST_BULK || state == ST_VOLTAGE);

    safety_timer #(.LIMIT(TRICKLE_TICKS)) trickleTimer (
        .mclk(mclk),
        .rst(rst),
        .clear(state != ST_TRICKLE),
        .advance(timerAdvance && !suspended),
        .expired(trickleExpired)
    );

    safety_timer #(.LIMIT(BULK_TICKS)) bulkTimer (
        .mclk(mclk),
        .rst(rst),
        .clear(state != ST_BULK),
        .advance(timerAdvance && !suspended),
        .expired(bulkExpired)
    );

    safety_timer #(.LIMIT(OVERALL_TICKS)) overallTimer (
        .mclk(mclk),
        .rst(rst),
        .clear(state != ST_BULK && state != ST_VOLTAGE),
        .advance(timerAdvance && !suspended),
        .expired(overallExpired)
    );

    // =========================================================
    // Phase sequencing
    assign qualified = !supplyLockout && chargePermitIn && cellTempSenseOk;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (chargePermitIn) begin
                    next_state = ST_QUAL;
                end
            end
            ST_QUAL: begin
                if (qualified) begin
                    next_state = trickleExitReached ? ST_BULK : ST_TRICKLE;
                end
            end
            ST_TRICKLE: begin
                if (trickleExitReached) begin
                    next_state = ST_BULK;
                end else if (trickleExpired) begin
                    next_state = ST_FAULT;
                end
            end
            ST_BULK: begin
                if (targetVoltageReached) begin
                    next_state = ST_VOLTAGE;
                end else if (bulkExpired) begin
                    next_state = ST_FAULT;
                end else if (overallExpired) begin
                    next_state = ST_DONE;
                end
            end
            ST_VOLTAGE: begin
                if (termCurrentReached || overallExpired) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (belowRechargeThreshold && qualified) begin
                    next_state = ST_QUAL;
                end
            end
            ST_FAULT: begin
                next_state = ST_FAULT;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (suspended) begin
            next_state = state;
        end
        // Lockout and a low permit win over every phase, fault included.
        if (supplyLockout || !chargePermitIn) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // =========================================================
    // Analog control levels
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            trickleMode <= 1'b0;
            bulkMode <= 1'b0;
            voltageMode <= 1'b0;
            targetHigh <= 1'b0;
            lowPower <= 1'b1;
        end else begin
            trickleMode <= next_state == ST_TRICKLE && !suspended;
            bulkMode <= next_state == ST_BULK && !suspended;
            voltageMode <= next_state == ST_VOLTAGE && !suspended;
            targetHigh <= regulationLevelSelect;
            lowPower <= supplyLockout || !chargePermitIn;
        end
    end

    // =========================================================
    // Indicators
    // Open drain: data is tied low and the enable lets the pin sink.
    assign chargeIndicatorOut = 1'b0;
    assign faultIndicatorOut = 1'b0;

    always @* begin
        chargeOn = 1'b0;
        faultOn = 1'b0;
        case (state)
            ST_QUAL: begin
                faultOn = suspended && flashPhase;
            end
            ST_TRICKLE, ST_BULK, ST_VOLTAGE: begin
                chargeOn = !suspended;
                faultOn = suspended && flashPhase;
            end
            ST_DONE: begin
                chargeOn = flashOnComplete && flashPhase && cellTempSenseOk;
            end
            ST_FAULT: begin
                faultOn = 1'b1;
            end
            default: begin
                chargeOn = 1'b0;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            chargeIndicatorOeN <= 1'b1;
            faultIndicatorOeN <= 1'b1;
        end else begin
            chargeIndicatorOeN <= !chargeOn;
            faultIndicatorOeN <= !faultOn;
        end
    end

    // =========================================================
    // Register bank
    axi_lite_port busPort (
        .mclk(mclk),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // Status is read-only; a write to it is refused like an unmapped one.
    assign wrOk = wrAddr == `ADDR_CONTROL || wrAddr == `ADDR_TIMING;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            flashOnComplete <= `CTRL_RESET;
            capRatio <= `CAP_RATIO_RESET;
        end else if (wrEn && wrStrb[0]) begin
            if (wrAddr == `ADDR_CONTROL) begin
                flashOnComplete <= wrData[`CTRL_FLASH_BIT];
            end
            if (wrAddr == `ADDR_TIMING) begin
                capRatio <= wrData[7:0];
            end
        end
    end

    always @* begin
        rdData = 32'h00000000;
        rdOk = 1'b1;
        case (rdAddr)
            `ADDR_CONTROL: begin
                rdData[`CTRL_FLASH_BIT] = flashOnComplete;
            end
            `ADDR_TIMING: begin
                rdData[7:0] = capRatio;
            end
            `ADDR_STATUS: begin
                rdData[9:0] = {flashPhase, faultIndicatorIn, chargeIndicatorIn, overallExpired,
                    bulkExpired, trickleExpired, suspended, state};
            end
            default: begin
                rdOk = 1'b0;
            end
        endcase
    end
endmodule

// ---- src/charge_seq_defines.vh ----
// Constants shared by the charge cycle sequencer files.
// Summary of operation
// - Three safety periods scale with capacitor: 1.0 h, 1.5 h, 3.0 h per 0.1 uF.
// - Trickle timer starts after qualification, clears on entering constant current.
// - Bulk and overall timers both start when trickle phase is left.
// - Bulk timer clears on entering constant voltage.
// - Overall timer expiry ends the cycle if current never fell below termination.
// - Thermal regulation slows timers in proportion to the reduced charge current.
// - Both indicators off in qualification; charge on, fault off while charging.
// - Complete: fault off; charge flashes 1 Hz 50% or stays off, per variant.
// - Flash rate comes from the capacitor clock, 1 Hz at 0.1 uF.
// - Fault state: charge indicator off, fault indicator steadily on.
// - Fault leaves only on supply cycling or permit going low then high.
// - Temperature out of window blocks or suspends the cycle, no termination, no fault.
// - Cycle resumes or starts automatically once temperature and qualification are good.
// - Invalid temperature: charge indicator off, fault indicator flashes; when complete, the design keeps the fault indicator off.
// - Level select picks lower target voltage when low, higher when high.
// - Permit input can end a charge anytime and start a new or recharge cycle.
// - Permit high enables; permit low disables and terminates the running cycle.
// - Supply below lockout level puts the device into low-power state.
// - Qualify on supply, permit and temperature; keep checking them throughout.
// - Trickle timer expiry before trickle exit threshold gives a fault.
// - Bulk timer expiry before target voltage gives a fault.
// - After completion, recharge starts when voltage drops below recharge threshold.
`ifndef CHARGE_SEQ_DEFINES_VH
`define CHARGE_SEQ_DEFINES_VH

`define ADDR_CONTROL 4'h0
`define ADDR_TIMING 4'h4
`define ADDR_STATUS 4'h8
`define CTRL_FLASH_BIT 0
`define CTRL_RESET 1'b1
`define CAP_RATIO_RESET 8'h01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define MCLK_HZ 100000000
`define FLASH_HZ 1
`define TRICKLE_LIMIT_TENTHS_H 10
`define BULK_LIMIT_TENTHS_H 15
`define OVERALL_LIMIT_TENTHS_H 30
`define HALF_SECONDS_PER_TENTH_H 720

`endif

// ---- src/safety_timer.v ----
// Safety timer counting capacitor-clock ticks up to a fixed limit.
`timescale 1ns/10ps
module safety_timer #(
    parameter [15:0] LIMIT = 16'h0001
) (
    input wire mclk,
    input wire rst,
    input wire clear,
    input wire advance,
    output reg expired
);
    reg [15:0] count;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
            expired <= 1'b0;
        end else if (clear) begin
            count <= 16'h0000;
            expired <= 1'b0;
        end else if (advance && !expired) begin
            if (count == LIMIT - 16'h0001) begin
                expired <= 1'b1;
            end
            count <= count + 16'h0001;
        end
    end
endmodule

// ---- verif/charge_cycle_sequencer_checker.sv ----
// Port-level assertions for the charge cycle sequencer.
`timescale 1ns/10ps
module charge_seq_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic supplyLockout,
    input wire logic chargePermitIn,
    input wire logic cellTempSenseOk,
    input wire logic regulationLevelSelect,
    input wire logic trickleExitReached,
    input wire logic trickleMode,
    input wire logic bulkMode,
    input wire logic voltageMode,
    input wire logic targetHigh,
    input wire logic lowPower,
    input wire logic chargeIndicatorOeN,
    input wire logic faultIndicatorOeN
);
    // ==========
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire charging = trickleMode | bulkMode | voltageMode;
    // Three samples let the registered pins settle.
    sequence s_tempBad;
        !cellTempSenseOk [*3];
    endsequence
    sequence s_permitRestart;
        !chargePermitIn ##1 (chargePermitIn && !supplyLockout && cellTempSenseOk) [*3];
    endsequence
    property p_chargeOn;
        charging && cellTempSenseOk |=> !chargeIndicatorOeN && faultIndicatorOeN;
    endproperty
    property p_permitLow;
        !chargePermitIn |=> lowPower && !charging;
    endproperty
    property p_lockout;
        supplyLockout |=> lowPower && !charging;
    endproperty
    property p_target;
        1 |=> targetHigh == $past(regulationLevelSelect);
    endproperty
    property p_faultExcl;
        !faultIndicatorOeN |-> chargeIndicatorOeN;
    endproperty
    property p_suspend;
        s_tempBad |-> !charging;
    endproperty
    property p_tempOff;
        s_tempBad |-> chargeIndicatorOeN;
    endproperty
    property p_trickleExit;
        trickleMode && trickleExitReached && cellTempSenseOk && chargePermitIn && !supplyLockout
            |=> bulkMode && !trickleMode;
    endproperty
    property p_restart;
        s_permitRestart |-> charging;
    endproperty
    a_chargeOn: assert property (p_chargeOn)
        else $error("charge indicator not on while charging");
    a_permitLow: assert property (p_permitLow)
        else $error("permit low did not stop the cycle");
    a_lockout: assert property (p_lockout)
        else $error("lockout did not enter low power");
    a_target: assert property (p_target)
        else $error("target level does not follow select");
    a_faultExcl: assert property (p_faultExcl)
        else $error("both indicators on together");
    a_suspend: assert property (p_suspend)
        else $error("charging while temperature invalid");
    a_tempOff: assert property (p_tempOff)
        else $error("charge indicator on while temperature invalid");
    a_trickleExit: assert property (p_trickleExit)
        else $error("trickle exit did not start bulk phase");
    a_restart: assert property (p_restart)
        else $error("permit cycle did not restart charging");
endmodule

bind charge_cycle_sequencer charge_seq_checker chk (.mclk, .rst, .supplyLockout, .chargePermitIn,
    .cellTempSenseOk, .regulationLevelSelect, .trickleExitReached, .trickleMode, .bulkMode, .voltageMode,
    .targetHigh, .lowPower, .chargeIndicatorOeN, .faultIndicatorOeN);

// ---- verif/status_led_model.sv ----
// Pull-up model for the two open-drain status pins.
`timescale 1ns/10ps
module status_led_model (
    input wire logic chargeOeN,
    input wire logic chargeOut,
    input wire logic faultOeN,
    input wire logic faultOut,
    output wire logic chargePin,
    output wire logic faultPin
);
    // ==========
    // Pin levels
    // A released pin is pulled up, so an LED that is off reads back high.
    assign chargePin = chargeOeN ? 1'b1 : chargeOut;
    assign faultPin = faultOeN ? 1'b1 : faultOut;
endmodule

// ---- verif/test_charge_cycle_sequencer.sv ----
// Self-checking bench for the charge cycle sequencer.
`timescale 1ns/10ps
module test_charge_cycle_sequencer;
    // ==========
    // Signals
    localparam int HP = 4;
    localparam int TRICKLE_CYC = 2 * 3600 * HP;
    localparam int BULK_CYC = 3 * 3600 * HP;
    logic mclk, rst, supplyLockout, chargePermitIn, cellTempSenseOk, regulationLevelSelect;
    logic trickleExitReached, targetVoltageReached, termCurrentReached, belowRechargeThreshold;
    logic thermalRegActive, awvalid, wvalid, bready, arvalid, rready, measFault, wr;
    logic [3:0] currentShare, awaddr, wstrb, araddr, ra;
    logic [31:0] wdata, gotD, rd;
    logic [1:0] gotR, rr;
    wire trickleMode, bulkMode, voltageMode, targetHigh, lowPower, awready, wready, bvalid, arready, rvalid;
    wire chargeIndicatorIn, chargeIndicatorOut, chargeIndicatorOeN;
    wire faultIndicatorIn, faultIndicatorOut, faultIndicatorOeN;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire measPin = measFault ? faultIndicatorOeN : chargeIndicatorOeN;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    logic [38:0] rows [11] = '{{1'h0, 4'h0, 32'h1, 2'h0}, {1'h0, 4'h4, 32'h1, 2'h0}, {1'h0, 4'hc, 32'h0, 2'h2},
        {1'h1, 4'h8, 32'h7, 2'h2}, {1'h1, 4'hc, 32'h1, 2'h2}, {1'h1, 4'h4, 32'h2, 2'h0},
        {1'h0, 4'h4, 32'h2, 2'h0}, {1'h1, 4'h4, 32'h1, 2'h0}, {1'h1, 4'h0, 32'h0, 2'h0},
        {1'h0, 4'h0, 32'h0, 2'h0}, {1'h1, 4'h0, 32'h1, 2'h0}};

    charge_cycle_sequencer #(.HALF_PERIOD_CYCLES(HP)) dut (
        .mclk, .rst, .supplyLockout, .chargePermitIn, .cellTempSenseOk, .regulationLevelSelect,
        .trickleExitReached, .targetVoltageReached, .termCurrentReached, .belowRechargeThreshold,
        .thermalRegActive, .currentShare, .trickleMode, .bulkMode, .voltageMode, .targetHigh, .lowPower,
        .chargeIndicatorIn, .chargeIndicatorOut, .chargeIndicatorOeN, .faultIndicatorIn, .faultIndicatorOut,
        .faultIndicatorOeN, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    status_led_model leds (.chargeOeN(chargeIndicatorOeN), .chargeOut(chargeIndicatorOut),
        .faultOeN(faultIndicatorOeN), .faultOut(faultIndicatorOut), .chargePin(chargeIndicatorIn),
        .faultPin(faultIndicatorIn));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========
    // Tasks
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic waitCyc(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // Address and data are released as each is taken.
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        ta = 1'b0;
        tw = 1'b0;
        while (!(ta && tw)) begin
            @(posedge mclk);
            ta = ta | awready;
            tw = tw | wready;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(posedge mclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic togglePeriod(output int k);
        logic v;
        v = measPin;
        do @(posedge mclk); while (measPin === v);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (measPin !== v);
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 92000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ==========
    // Sequence
    initial begin
        rst = 1'b1;
        {supplyLockout, chargePermitIn, regulationLevelSelect, trickleExitReached, measFault} = '0;
        {targetVoltageReached, termCurrentReached, belowRechargeThreshold, thermalRegActive} = '0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, currentShare} = '0;
        cellTempSenseOk = 1'b1;
        wstrb = 4'hf;
        waitCyc(5);
        rst <= 1'b0;
        waitCyc(2);
        check({lowPower, chargeIndicatorIn}, 2'h3);
        foreach (rows[i]) begin
            {wr, ra, rd, rr} = rows[i];
            if (wr) begin
                axiWrite(ra, rd, gotR);
            end else begin
                axiRead(ra, gotD, gotR);
                check(gotD, rd);
            end
            check(gotR, rr);
        end
        regulationLevelSelect <= 1'b1;
        waitCyc(3);
        check(targetHigh, 1'b1);
        regulationLevelSelect <= 1'b0;
        waitCyc(3);
        check(targetHigh, 1'b0);
        // Half current share halves the timer rate.
        thermalRegActive <= 1'b1;
        currentShare <= 4'h8;
        chargePermitIn <= 1'b1;
        waitCyc(3);
        check({chargeIndicatorOeN, faultIndicatorOeN, trickleMode}, 3'h7);
        waitCyc(1);
        check({chargeIndicatorOeN, faultIndicatorOeN}, 2'h1);
        waitCyc(TRICKLE_CYC);
        check({faultIndicatorOeN, trickleMode}, 2'h3);
        thermalRegActive <= 1'b0;
        waitCyc(TRICKLE_CYC / 2 - 80);
        check(faultIndicatorOeN, 1'b1);
        waitCyc(160);
        check({chargeIndicatorOeN, faultIndicatorOeN, trickleMode}, 3'h4);
        trickleExitReached <= 1'b1;
        repeat (3 * HP) begin
            waitCyc(1);
            check(faultIndicatorOeN, 1'b0);
        end
        axiRead(4'h8, gotD, gotR);
        check(gotD[2:0], 3'h6);
        chargePermitIn <= 1'b0;
        waitCyc(1);
        chargePermitIn <= 1'b1;
        waitCyc(3);
        check({bulkMode, faultIndicatorOeN}, 2'h3);
        measFault <= 1'b1;
        cellTempSenseOk <= 1'b0;
        togglePeriod(n);
        check(n, HP);
        check({bulkMode, chargeIndicatorOeN}, 2'h1);
        cellTempSenseOk <= 1'b1;
        waitCyc(3);
        check({bulkMode, faultIndicatorOeN}, 2'h3);
        targetVoltageReached <= 1'b1;
        waitCyc(3);
        check({bulkMode, voltageMode}, 2'h1);
        termCurrentReached <= 1'b1;
        measFault <= 1'b0;
        waitCyc(3);
        togglePeriod(n);
        check(n, HP);
        check(faultIndicatorOeN, 1'b1);
        axiWrite(4'h0, 32'h0, gotR);
        waitCyc(2);
        repeat (3 * HP) begin
            waitCyc(1);
            check(chargeIndicatorOeN, 1'b1);
        end
        axiWrite(4'h0, 32'h1, gotR);
        {targetVoltageReached, termCurrentReached, belowRechargeThreshold} <= 3'h1;
        waitCyc(4);
        check(bulkMode, 1'b1);
        belowRechargeThreshold <= 1'b0;
        supplyLockout <= 1'b1;
        waitCyc(2);
        check({lowPower, bulkMode}, 2'h2);
        supplyLockout <= 1'b0;
        waitCyc(3);
        check(bulkMode, 1'b1);
        waitCyc(BULK_CYC - 80);
        check(faultIndicatorOeN, 1'b1);
        waitCyc(160);
        check({chargeIndicatorOeN, faultIndicatorOeN}, 2'h2);
        print_verdict();
    end
endmodule
